// >>> src/nva_pkg.sv
// constants and types shared by the nonvolatile data access block
package nva_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_PERIPH_FLAGS = 8'h0c;
    localparam logic [7:0] IDX_NVM_DATA = 8'h9a;
    localparam logic [7:0] IDX_NVM_ADDR = 8'h9b;
    localparam logic [7:0] IDX_NVM_CTRL = 8'h9c;
    localparam logic [7:0] IDX_NVM_UNLOCK = 8'h9d;

    // control and flags register fields
    localparam int CTRL_RD_BIT = 0;
    localparam int CTRL_WR_BIT = 1;
    localparam int CTRL_PERMIT_BIT = 2;
    localparam int CTRL_ABORT_BIT = 3;
    localparam int FLAGS_DONE_BIT = 7;

    // reset values and fixed patterns
    localparam logic [7:0] NVM_DATA_RST = 8'h00;
    localparam logic [7:0] NVM_ADDR_RST = 8'h00;
    localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_KEY_SECOND = 8'haa;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int STORE_TIME_NS = 4000000;
    localparam int STORE_CYCLES_DEF = STORE_TIME_NS / CLK_PERIOD_NS;
    localparam int UNLOCK_WINDOW_CYC = 16;

    typedef enum logic [2:0] {
        UNL_IDLE = 3'b001,
        UNL_GOT_FIRST = 3'b010,
        UNL_ARMED = 3'b100
    } nva_unlock_e;

endpackage

// >>> src/nva_data_access.sv
// nonvolatile data array with register access over an AXI4-Lite slave
// Functional notes
// - Array holds 128 bytes, addressed 0 to 7Fh by the address register.
// - Only the low seven address bits select a byte; bit 7 ignored.
// - Data register holds the byte to write or the byte read.
// - Each byte store erases the location, then programs the new value.
// - Store duration is timed by an internal counter, not by software.
// - Under data protection the CPU keeps access; programming port is refused.
// - Control register implements four low bits; bits 7 to 4 read zero.
// - Software can set read and store strobes but never clear them.
// - Read strobe starts a one-cycle read; hardware clears it.
// - Store strobe starts a store; hardware clears it when done.
// - Store permit bit allows stores when set, blocks them when clear.
// - Store permit is zero after power-up.
// - Abort flag sets when a reset input cuts an active store short.
// - Reset that aborts a store clears data and address; software retries.
// - Store-done flag sets on completion; only software clears it.
// - Unlock port stores nothing, reads zero, only accepts the key sequence.
// - Store starts only after 55h, AAh to unlock port, then strobe, promptly.
// - Store strobe cannot be set unless permit was already set.
// - Clearing permit during a store does not stop that store.
// - Read data appears the cycle after the strobe and stays until changed.
`timescale 1ns/1ps
`default_nettype none

module nva_data_access
    import nva_pkg::*;
#(
    parameter int ADDR_W = 10,
    parameter int NVM_DEPTH = 128,
    parameter int NVM_AW = 7,
    parameter int STORE_CYCLES = STORE_CYCLES_DEF
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic external_reset_pin,
    input wire logic watchdog_timeout,
    input wire logic brownout_detect,
    input wire logic code_protect,
    input wire logic prog_valid,
    output logic prog_ready,
    input wire logic prog_write,
    input wire logic [NVM_AW-1:0] prog_addr,
    input wire logic [7:0] prog_wdata,
    output logic [7:0] prog_rdata,
    output logic prog_done,
    output logic prog_denied,
    output logic store_busy,
    output logic store_done_flag
);

    localparam int CNT_W = $clog2(STORE_CYCLES + 1);
    localparam int IDX_W = ADDR_W - 2;

    // refused at elaboration: the highest register index needs eight index bits
    if (ADDR_W < 10 || NVM_DEPTH != (1 << NVM_AW) || NVM_AW > 7 || STORE_CYCLES < 1)
    begin : g_param_check
        $error("nva_data_access: unsupported parameter set");
    end

    typedef struct packed {
        logic aw_held;
        logic [IDX_W-1:0] aw_idx;
        logic w_held;
        logic [7:0] w_byte;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [7:0] nvm_data;
        logic [7:0] nvm_addr;
        logic rd;
        logic wr;
        logic permit;
        logic abort;
        logic done;
        nva_unlock_e unl;
        logic [4:0] unl_cnt;
        logic [CNT_W-1:0] store_cnt;
        logic [NVM_AW-1:0] st_addr;
        logic [7:0] st_data;
        logic [7:0] prog_rdata;
        logic prog_done;
        logic prog_denied;
    } nva_state_s;

    nva_state_s st_reg;
    nva_state_s st_next;

    logic [7:0] mem [NVM_DEPTH];
    logic mem_we;
    logic [NVM_AW-1:0] mem_wa;
    logic [7:0] mem_wd;
    logic dev_rst;
    logic do_write;
    logic do_read;
    logic [7:0] rd_byte;

    function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
        return idx == IDX_W'(IDX_PERIPH_FLAGS) || idx == IDX_W'(IDX_NVM_DATA)
            || idx == IDX_W'(IDX_NVM_ADDR) || idx == IDX_W'(IDX_NVM_CTRL)
            || idx == IDX_W'(IDX_NVM_UNLOCK);
    endfunction

    assign dev_rst = external_reset_pin | watchdog_timeout | brownout_detect;
    assign do_write = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
    assign do_read = s_axi_arvalid && !st_reg.rvalid;
    // bit 7 of the address never reaches the array
    assign rd_byte = mem[st_reg.nvm_addr[NVM_AW-1:0]];

    assign s_axi_awready = !st_reg.aw_held;
    assign s_axi_wready = !st_reg.w_held;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rresp = st_reg.rresp;
    assign s_axi_rdata = {24'h000000, st_reg.rdata};
    // programming port waits while the array is busy with a store
    assign prog_ready = !st_reg.wr && !do_write;
    assign prog_rdata = st_reg.prog_rdata;
    assign prog_done = st_reg.prog_done;
    assign prog_denied = st_reg.prog_denied;
    assign store_busy = st_reg.wr;
    assign store_done_flag = st_reg.done;

    always_comb
    begin
        logic [7:0] rv;
        logic [7:0] wb;
        rv = ZERO_BYTE;
        wb = st_reg.w_byte;
        st_next = st_reg;
        mem_we = 1'b0;
        mem_wa = '0;
        mem_wd = ZERO_BYTE;
        st_next.prog_done = 1'b0;
        st_next.prog_denied = 1'b0;

        // bus channel capture
        if (s_axi_awvalid && !st_reg.aw_held)
        begin
            st_next.aw_held = 1'b1;
            st_next.aw_idx = s_axi_awaddr[ADDR_W-1:2];
        end
        if (s_axi_wvalid && !st_reg.w_held)
        begin
            st_next.w_held = 1'b1;
            st_next.w_byte = s_axi_wdata[7:0];
            st_next.w_lane0 = s_axi_wstrb[0];
        end
        if (st_reg.bvalid && s_axi_bready)
            st_next.bvalid = 1'b0;
        if (st_reg.rvalid && s_axi_rready)
            st_next.rvalid = 1'b0;

        // read strobe lasts one cycle and loads the data register
        if (st_reg.rd)
        begin
            st_next.rd = 1'b0;
            st_next.nvm_data = rd_byte;
        end

        // unlock sequence must keep pace
        if (st_reg.unl != UNL_IDLE)
        begin
            if (st_reg.unl_cnt == 5'(UNLOCK_WINDOW_CYC - 1))
                st_next.unl = UNL_IDLE;
            else
                st_next.unl_cnt = st_reg.unl_cnt + 5'd1;
        end

        // store engine, timed internally; permit is not looked at once running
        if (st_reg.wr)
        begin
            if (st_reg.store_cnt == '0)
            begin
                st_next.wr = 1'b0;
                st_next.done = 1'b1;
                mem_we = 1'b1;
                mem_wa = st_reg.st_addr;
                mem_wd = st_reg.st_data;
            end
            else
                st_next.store_cnt = st_reg.store_cnt - CNT_W'(1);
        end

        if (do_write)
        begin
            st_next.aw_held = 1'b0;
            st_next.w_held = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = idx_mapped(st_reg.aw_idx) ? RESP_OKAY : RESP_SLVERR;
            // any write with the low byte lane, other than the next key step, breaks the sequence
            if (st_reg.w_lane0 && !(st_reg.aw_idx == IDX_W'(IDX_NVM_CTRL) && wb[CTRL_WR_BIT]))
                st_next.unl = UNL_IDLE;
            if (st_reg.w_lane0)
            begin
                case (st_reg.aw_idx)
                    IDX_W'(IDX_PERIPH_FLAGS):
                        // completion in the same cycle keeps the flag set
                        if (!wb[FLAGS_DONE_BIT] && !(st_reg.wr && st_reg.store_cnt == '0))
                            st_next.done = 1'b0;
                    IDX_W'(IDX_NVM_DATA):
                        st_next.nvm_data = wb;
                    IDX_W'(IDX_NVM_ADDR):
                        st_next.nvm_addr = wb;
                    IDX_W'(IDX_NVM_CTRL):
                    begin
                        st_next.permit = wb[CTRL_PERMIT_BIT];
                        st_next.abort = wb[CTRL_ABORT_BIT];
                        if (wb[CTRL_RD_BIT])
                            st_next.rd = 1'b1;
                        // zero in a strobe bit leaves it alone
                        if (wb[CTRL_WR_BIT])
                        begin
                            st_next.unl = UNL_IDLE;
                            if (!st_reg.wr && st_reg.permit && st_reg.unl == UNL_ARMED)
                            begin
                                st_next.wr = 1'b1;
                                st_next.store_cnt = CNT_W'(STORE_CYCLES - 1);
                                st_next.st_addr = st_reg.nvm_addr[NVM_AW-1:0];
                                st_next.st_data = st_reg.nvm_data;
                                mem_we = 1'b1;
                                mem_wa = st_reg.nvm_addr[NVM_AW-1:0];
                                mem_wd = ERASED_BYTE;
                            end
                        end
                    end
                    IDX_W'(IDX_NVM_UNLOCK):
                    begin
                        st_next.unl_cnt = 5'd0;
                        if (wb == UNLOCK_KEY_FIRST)
                            st_next.unl = UNL_GOT_FIRST;
                        else if (wb == UNLOCK_KEY_SECOND && st_reg.unl == UNL_GOT_FIRST)
                            st_next.unl = UNL_ARMED;
                        else
                            st_next.unl = UNL_IDLE;
                    end
                    default:
                        st_next.unl = UNL_IDLE;
                endcase
            end
        end

        if (do_read)
        begin
            case (s_axi_araddr[ADDR_W-1:2])
                IDX_W'(IDX_PERIPH_FLAGS):
                    rv = {st_reg.done, 7'h00};
                IDX_W'(IDX_NVM_DATA):
                    rv = st_reg.nvm_data;
                IDX_W'(IDX_NVM_ADDR):
                    rv = st_reg.nvm_addr;
                IDX_W'(IDX_NVM_CTRL):
                    rv = {4'h0, st_reg.abort, st_reg.permit, st_reg.wr, st_reg.rd};
                default:
                    rv = ZERO_BYTE;
            endcase
            st_next.rvalid = 1'b1;
            st_next.rdata = rv;
            st_next.rresp = idx_mapped(s_axi_araddr[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
        end

        // programming port: refused while data protection holds
        if (prog_valid && prog_ready)
        begin
            if (code_protect)
                st_next.prog_denied = 1'b1;
            else
            begin
                st_next.prog_done = 1'b1;
                st_next.prog_rdata = mem[prog_addr];
                if (prog_write)
                begin
                    mem_we = 1'b1;
                    mem_wa = prog_addr;
                    mem_wd = prog_wdata;
                end
            end
        end

        // device reset inputs abort a store and clear the access registers
        if (dev_rst)
        begin
            if (st_reg.wr)
                st_next.abort = 1'b1;
            st_next.done = st_reg.done;
            st_next.wr = 1'b0;
            st_next.rd = 1'b0;
            st_next.permit = 1'b0;
            st_next.nvm_data = NVM_DATA_RST;
            st_next.nvm_addr = NVM_ADDR_RST;
            st_next.unl = UNL_IDLE;
            st_next.unl_cnt = 5'd0;
            st_next.prog_done = 1'b0;
            mem_we = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_reg <= '0;
            st_reg.unl <= UNL_IDLE;
            st_reg.nvm_data <= NVM_DATA_RST;
            st_reg.nvm_addr <= NVM_ADDR_RST;
            st_reg.permit <= 1'b0;
        end
        else
            st_reg <= st_next;
    end

    // array contents survive reset
    always_ff @(posedge aclk)
    begin
        if (mem_we)
            mem[mem_wa] <= mem_wd;
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_store_start;
        !st_reg.wr ##1 st_reg.wr;
    endsequence

    sequence s_store_end;
        st_reg.wr && st_reg.store_cnt == '0 && !dev_rst;
    endsequence

    a_read_autoclear: assert property (st_reg.rd |=> !st_reg.rd)
        else $error("read strobe not cleared");
    a_read_data_next: assert property (st_reg.rd && !dev_rst && !do_write |=>
        st_reg.nvm_data == $past(rd_byte))
        else $error("read data not loaded");
    a_ctrl_upper_zero: assert property (do_read
        && s_axi_araddr[ADDR_W-1:2] == IDX_W'(IDX_NVM_CTRL) |=> st_reg.rdata[7:4] == 4'h0)
        else $error("control upper bits not zero");
    a_start_needs_permit: assert property (s_store_start |-> $past(st_reg.permit, 1))
        else $error("store began without permit");
    a_start_needs_key: assert property (s_store_start |-> $past(st_reg.unl, 1) == UNL_ARMED)
        else $error("store began without unlock");
    a_store_done_set: assert property (s_store_end |=> !st_reg.wr && st_reg.done)
        else $error("completion not flagged");
    a_permit_no_stop: assert property (st_reg.wr && st_reg.store_cnt != '0 && !dev_rst
        |=> st_reg.wr)
        else $error("store stopped early");
    a_abort_clears: assert property (st_reg.wr && dev_rst |=>
        st_reg.abort && st_reg.nvm_data == NVM_DATA_RST && st_reg.nvm_addr == NVM_ADDR_RST)
        else $error("abort not handled");
    a_prog_refused: assert property (prog_valid && prog_ready && code_protect && !dev_rst
        |=> st_reg.prog_denied && !st_reg.prog_done)
        else $error("protected access allowed");
    a_done_sticky: assert property (st_reg.done && !do_write |=> st_reg.done)
        else $error("done flag lost");

endmodule // nva_data_access

`default_nettype wire

// >>> verif/nva_data_access_bench.sv
// self-checking bench for the nonvolatile data access block
`timescale 1ns/1ps
`default_nettype none

module nva_data_access_bench
    import nva_pkg::*;
;
    localparam int SC = 20;
    logic aclk, aresetn;
    logic [9:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [2:0] rst_src;
    logic code_protect, prog_valid, prog_ready, prog_write, prog_done, prog_denied;
    logic [6:0] prog_addr;
    logic [7:0] prog_wdata, prog_rdata;
    logic store_busy, store_done_flag;
    logic [31:0] rd;
    int err_total, n_compared, cyc;
    typedef struct {logic [7:0] idx; logic [7:0] wd; logic [31:0] rd; logic [1:0] resp;} nva_row_s;
    nva_row_s rows [6];

    nva_data_access #(.STORE_CYCLES(SC)) u_nva_data_access (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .external_reset_pin(rst_src[0]), .watchdog_timeout(rst_src[1]),
        .brownout_detect(rst_src[2]), .code_protect(code_protect), .prog_valid(prog_valid),
        .prog_ready(prog_ready), .prog_write(prog_write), .prog_addr(prog_addr),
        .prog_wdata(prog_wdata), .prog_rdata(prog_rdata), .prog_done(prog_done),
        .prog_denied(prog_denied), .store_busy(store_busy), .store_done_flag(store_done_flag)
    );

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // hang guard: the whole run needs a few hundred cycles
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            end_of_test();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d);
        logic aw_ok, w_ok, b_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        b_ok = 1'b0;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b_ok)
        begin
            @(posedge aclk);
            if (s_axi_bvalid)
            begin
                // bready is driven high again on every call and is left high after the response
                b_ok = 1'b1;
                resp = s_axi_bresp;
            end
            if (!aw_ok && s_axi_awready)
            begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready)
            begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
    endtask

    task automatic axi_rd(input logic [7:0] idx);
        logic ar_ok, r_ok;
        ar_ok = 1'b0;
        r_ok = 1'b0;
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r_ok)
        begin
            @(posedge aclk);
            if (s_axi_rvalid)
            begin
                r_ok = 1'b1;
                rd = s_axi_rdata;
                resp = s_axi_rresp;
            end
            if (!ar_ok && s_axi_arready)
            begin
                ar_ok = 1'b1;
                s_axi_arvalid <= 1'b0;
            end
        end
    endtask

    // steps must stay close together or the unlock state drops
    task automatic start_store(input logic [7:0] a, input logic [7:0] d, input logic [7:0] k1);
        axi_wr(IDX_NVM_ADDR, a);
        axi_wr(IDX_NVM_DATA, d);
        axi_wr(IDX_NVM_CTRL, 8'h04);
        axi_wr(IDX_NVM_UNLOCK, k1);
        axi_wr(IDX_NVM_UNLOCK, k1 ^ 8'hff);
        axi_wr(IDX_NVM_CTRL, 8'h06);
    endtask

    task automatic prog_op(input logic wr, input logic [6:0] a, input logic [7:0] d);
        prog_write <= wr;
        prog_addr <= a;
        prog_wdata <= d;
        prog_valid <= 1'b1;
        @(posedge aclk);
        while (!prog_ready)
            @(posedge aclk);
        prog_valid <= 1'b0;
        // answer pulse stands in the cycle after the accepting edge
        @(posedge aclk);
    endtask

    task automatic wait_idle();
        for (int k = 0; k < 3 * SC && store_busy !== 1'b0; k++)
            @(posedge aclk);
        @(posedge aclk);
    endtask

    initial
    begin
        err_total = 0;
        n_compared = 0;
        cyc = 0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'h1;
        rst_src = 3'h0;
        {code_protect, prog_valid, prog_write} = '0;
        prog_addr = '0;
        prog_wdata = '0;
        rows[0] = '{IDX_NVM_DATA, 8'ha5, 32'h000000a5, RESP_OKAY};
        rows[1] = '{IDX_NVM_ADDR, 8'h12, 32'h00000012, RESP_OKAY};
        rows[2] = '{IDX_NVM_CTRL, 8'hf0, 32'h00000000, RESP_OKAY};
        rows[3] = '{IDX_NVM_UNLOCK, 8'h5a, 32'h00000000, RESP_OKAY};
        rows[4] = '{IDX_PERIPH_FLAGS, 8'hff, 32'h00000000, RESP_OKAY};
        rows[5] = '{8'h10, 8'h3c, 32'h00000000, RESP_SLVERR};
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(IDX_NVM_CTRL);
        chk("ctrl_reset", rd, 32'h0);
        foreach (rows[i])
        begin
            axi_wr(rows[i].idx, rows[i].wd);
            chk("wr_resp", resp, rows[i].resp);
            axi_rd(rows[i].idx);
            chk("rd_data", rd, rows[i].rd);
            chk("rd_resp", resp, rows[i].resp);
        end
        // a write without the low byte lane must leave the data register alone
        s_axi_wstrb <= 4'h0;
        axi_wr(IDX_NVM_DATA, 8'h5a);
        s_axi_wstrb <= 4'h1;
        axi_rd(IDX_NVM_DATA);
        chk("strb_off", rd, 32'ha5);
        start_store(8'h05, 8'h3c, UNLOCK_KEY_FIRST);
        chk("busy_start", store_busy, 1'b1);
        // zero to the strobe and to permit must not end the store
        axi_wr(IDX_NVM_CTRL, 8'h00);
        axi_rd(IDX_NVM_CTRL);
        chk("ctrl_busy", rd, 32'h2);
        wait_idle();
        chk("done_flag", store_done_flag, 1'b1);
        axi_rd(IDX_PERIPH_FLAGS);
        chk("flags_done", rd, 32'h80);
        axi_wr(IDX_PERIPH_FLAGS, 8'h00);
        chk("done_clear", store_done_flag, 1'b0);
        axi_wr(IDX_NVM_DATA, 8'h00);
        axi_wr(IDX_NVM_ADDR, 8'h85);
        axi_wr(IDX_NVM_CTRL, 8'h01);
        axi_rd(IDX_NVM_DATA);
        chk("readback_a7", rd, 32'h3c);
        axi_rd(IDX_NVM_CTRL);
        chk("rd_strobe_clr", rd, 32'h0);
        // no permit, then a reversed key: neither may start a store
        axi_wr(IDX_NVM_UNLOCK, UNLOCK_KEY_FIRST);
        axi_wr(IDX_NVM_UNLOCK, UNLOCK_KEY_SECOND);
        axi_wr(IDX_NVM_CTRL, 8'h02);
        chk("no_permit", store_busy, 1'b0);
        start_store(8'h06, 8'h11, UNLOCK_KEY_SECOND);
        chk("bad_key", store_busy, 1'b0);
        for (int s = 0; s < 3; s++)
        begin
            start_store(8'h07, 8'h22, UNLOCK_KEY_FIRST);
            repeat (2) @(posedge aclk);
            rst_src <= 3'h1 << s;
            @(posedge aclk);
            rst_src <= 3'h0;
            @(posedge aclk);
            chk("abort_busy", store_busy, 1'b0);
            axi_rd(IDX_NVM_CTRL);
            chk("abort_flag", rd, 32'h8);
            axi_rd(IDX_NVM_DATA);
            chk("abort_data", rd, 32'h0);
            axi_rd(IDX_NVM_ADDR);
            chk("abort_addr", rd, 32'h0);
            axi_wr(IDX_NVM_CTRL, 8'h00);
        end
        prog_op(1'b1, 7'h09, 8'h77);
        chk("prog_wr", prog_done, 1'b1);
        prog_op(1'b0, 7'h09, 8'h00);
        chk("prog_rd", prog_rdata, 8'h77);
        code_protect <= 1'b1;
        prog_op(1'b0, 7'h09, 8'h00);
        chk("prog_denied", prog_denied, 1'b1);
        axi_wr(IDX_NVM_ADDR, 8'h09);
        axi_wr(IDX_NVM_CTRL, 8'h01);
        axi_rd(IDX_NVM_DATA);
        chk("cpu_protected", rd, 32'h77);
        end_of_test();
    end
endmodule // nva_data_access_bench

`default_nettype wire
